// *** design/dpab_consts.svh ***
`ifndef DPAB_CONSTS_SVH
`define DPAB_CONSTS_SVH

// Parameter numbers
`define DPAB_PAR_STATUS     8'h01
`define DPAB_PAR_SPEED      8'h02
`define DPAB_PAR_POSITION   8'h03
`define DPAB_PAR_TORQUE     8'h04
`define DPAB_PAR_PEAK       8'h05
`define DPAB_PAR_ULOGIC     8'h06
`define DPAB_PAR_UMOTOR     8'h07
`define DPAB_PAR_TEMP       8'h08
`define DPAB_PAR_SWITCH     8'h09
`define DPAB_PAR_DATE       8'h0a
`define DPAB_PAR_SERIAL     8'h0b

// Payload lengths in bytes
`define DPAB_WR_LEN16       3'h3
`define DPAB_WR_LEN32       3'h5
`define DPAB_RD_LEN16       3'h2
`define DPAB_RD_LEN32       3'h4

// Status flag layout
`define DPAB_STAT_RSVD_MASK 16'hfff3
`define DPAB_STAT_RUNNING   6

// Reset values
`define DPAB_POS_RESET      32'h0000_0000
`define DPAB_PEAK_RESET     16'h0000

`endif

// *** design/dpab_pkg.sv ***
package dpab_pkg;

    // Request handling states
    typedef enum logic [3:0] {
        DPAB_IDLE  = 4'b0001,
        DPAB_WRCOL = 4'b0010,
        DPAB_RDOUT = 4'b0100,
        DPAB_ERR   = 4'b1000
    } dpab_state_t;

    // Outcome codes of a request
    typedef enum logic [1:0] {
        DPAB_OK       = 2'h0,
        DPAB_IGNORED  = 2'h1,
        DPAB_REJECTED = 2'h2,
        DPAB_BADPAR   = 2'h3
    } dpab_result_t;

endpackage

// *** design/dpab_peak.sv ***
`timescale 1ns/100ps
`include "dpab_consts.svh"

// Peak torque tracker over the steady part of a run
module dpab_peak (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_run_start,
    input  wire logic        i_steady,
    input  wire logic [15:0] i_torque,
    output logic      [15:0] o_peak
);
    typedef struct packed {
        logic [15:0] peak;
    } dpab_peak_st_t;

    dpab_peak_st_t s_q;
    dpab_peak_st_t s_d;

    // Start-up and braking phases excluded through i_steady
    always_comb begin
        s_d = s_q;
        if (i_run_start) begin
            s_d.peak = `DPAB_PEAK_RESET;
        end else if (i_steady && i_torque > s_q.peak) begin
            s_d.peak = i_torque;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_q.peak <= `DPAB_PEAK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_peak = s_q.peak;

    property p_peak_mono;
        @(posedge i_clock) disable iff (i_rst)
        (!$past(i_rst) && !$past(i_run_start) && !i_run_start) |-> (o_peak >= $past(o_peak));
    endproperty
    a_peak_mono: assert property (p_peak_mono) else $error("peak fell mid run");
endmodule

// *** design/dpab_sync.sv ***
`timescale 1ns/100ps

// Two-stage synchroniser for pin levels
module dpab_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } dpab_sync_st_t;

    dpab_sync_st_t s_q;
    dpab_sync_st_t s_d;

    // First stage only feeds the second
    always_comb begin
        s_d      = s_q;
        s_d.meta = i_async;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.sync;
endmodule

// *** design/dpab_bank.sv ***
`timescale 1ns/100ps
`include "dpab_consts.svh"

module dpab_bank (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    // Request strobe, number and direction
    input  wire logic                 i_req_valid,
    input  wire logic                 i_req_write,
    input  wire logic [7:0]           i_req_param,
    // Write payload bytes, control byte first
    input  wire logic                 i_wr_valid,
    input  wire logic [7:0]           i_wr_byte,
    input  wire logic                 i_wr_last,
    // Read response bytes, most significant first
    output logic                      o_rd_valid,
    output logic      [7:0]           o_rd_byte,
    output logic                      o_rd_last,
    // Request completion
    output logic                      o_done,
    output dpab_pkg::dpab_result_t    o_result,
    output logic                      o_busy,
    // Drive state from the motion logic
    input  wire logic [15:0]          i_status,
    input  wire logic [15:0]          i_speed,
    input  wire logic [31:0]          i_position,
    input  wire logic [15:0]          i_torque,
    input  wire logic                 i_run_start,
    input  wire logic                 i_run_steady,
    input  wire logic [15:0]          i_u_logic,
    input  wire logic [15:0]          i_u_motor,
    input  wire logic [15:0]          i_temperature,
    input  wire logic [15:0]          i_switch_pins,
    input  wire logic [15:0]          i_year_week,
    input  wire logic [15:0]          i_serial,
    // Position re-reference command to the motion logic
    output logic                      o_ref_load,
    output logic      [31:0]          o_ref_value
);
    import dpab_pkg::*;

    typedef struct packed {
        dpab_state_t  state;
        logic         wr;
        logic [7:0]   param;
        logic [2:0]   cnt;
        logic [2:0]   len;
        logic [7:0]   ctrl;
        logic [31:0]  shift;
        logic         rd_valid;
        logic [7:0]   rd_byte;
        logic         rd_last;
        logic         done;
        dpab_result_t result;
        logic         ref_load;
        logic [31:0]  ref_value;
    } dpab_bank_st_t;

    dpab_bank_st_t s_q;
    dpab_bank_st_t s_d;
    logic [15:0]   switch_sync;
    logic [15:0]   peak;
    logic          known;
    logic          wide;
    logic          writable;
    logic [31:0]   rd_word;
    logic [2:0]    wr_len;
    logic [7:0]    sel_param;

    // Switches are a pin, synchronised before use
    dpab_sync #(
        .WIDTH (16)
    ) dpab_sync_inst (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_switch_pins),
        .o_sync  (switch_sync)
    );

    dpab_peak dpab_peak_inst (
        .i_clock     (i_clock),
        .i_rst       (i_rst),
        .i_run_start (i_run_start),
        .i_steady    (i_run_steady),
        .i_torque    (i_torque),
        .o_peak      (peak)
    );

    // Parameter decode and read mux; the number is only valid on the request edge
    always_comb begin
        sel_param = (s_q.state == DPAB_IDLE) ? i_req_param : s_q.param; // Held copy once busy
        known    = 1'b1;
        wide     = 1'b0;
        writable = 1'b0;
        rd_word  = 32'h0000_0000;
        unique case (sel_param)
            `DPAB_PAR_STATUS:   rd_word = {16'h0000, i_status & `DPAB_STAT_RSVD_MASK};
            `DPAB_PAR_SPEED:    rd_word = {16'h0000, i_speed};
            `DPAB_PAR_POSITION: begin
                wide     = 1'b1;
                writable = 1'b1;
                rd_word  = i_position;
            end
            `DPAB_PAR_TORQUE:   rd_word = {16'h0000, i_torque};
            `DPAB_PAR_PEAK:     rd_word = {16'h0000, peak};
            `DPAB_PAR_ULOGIC:   rd_word = {16'h0000, i_u_logic};
            `DPAB_PAR_UMOTOR:   rd_word = {16'h0000, i_u_motor};
            `DPAB_PAR_TEMP:     rd_word = {16'h0000, i_temperature};
            `DPAB_PAR_SWITCH:   rd_word = {16'h0000, switch_sync};
            `DPAB_PAR_DATE:     rd_word = {16'h0000, i_year_week};
            `DPAB_PAR_SERIAL:   rd_word = {16'h0000, i_serial};
            default:            known   = 1'b0;
        endcase
        wr_len = wide ? `DPAB_WR_LEN32 : `DPAB_WR_LEN16;
    end

    // Request sequencer
    always_comb begin
        s_d          = s_q;
        s_d.rd_valid = 1'b0;
        s_d.rd_last  = 1'b0;
        s_d.done     = 1'b0;
        s_d.ref_load = 1'b0;
        unique case (s_q.state)
            DPAB_IDLE: begin
                if (i_req_valid) begin
                    s_d.param = i_req_param;
                    s_d.wr    = i_req_write;
                    s_d.cnt   = 3'h0;
                    s_d.shift = rd_word;
                    if (!known) begin
                        // Unknown number: writes are still drained
                        s_d.result = DPAB_BADPAR;
                        s_d.state  = i_req_write ? DPAB_ERR : DPAB_IDLE;
                        s_d.done   = !i_req_write;
                    end else if (i_req_write) begin
                        s_d.len   = wr_len;
                        s_d.state = DPAB_WRCOL;
                    end else begin
                        s_d.len   = wide ? `DPAB_RD_LEN32 : `DPAB_RD_LEN16;
                        s_d.state = DPAB_RDOUT;
                        if (!wide) begin
                            s_d.shift = {rd_word[15:0], 16'h0000};
                        end
                    end
                end
            end
            DPAB_RDOUT: begin
                // One byte per cycle, high byte first
                s_d.rd_valid = 1'b1;
                s_d.rd_byte  = s_q.shift[31:24];
                s_d.shift    = {s_q.shift[23:0], 8'h00};
                s_d.cnt      = s_q.cnt + 3'h1;
                if (s_q.cnt + 3'h1 == s_q.len) begin
                    s_d.rd_last = 1'b1;
                    s_d.done    = 1'b1;
                    s_d.result  = DPAB_OK;
                    s_d.state   = DPAB_IDLE;
                end
            end
            DPAB_WRCOL: begin
                if (i_wr_valid) begin
                    // First byte is the control byte
                    if (s_q.cnt == 3'h0) begin
                        s_d.ctrl = i_wr_byte;
                    end else begin
                        s_d.shift = {s_q.shift[23:0], i_wr_byte};
                    end
                    s_d.cnt = s_q.cnt + 3'h1;
                    if (i_wr_last || s_q.cnt + 3'h1 == s_q.len) begin
                        s_d.done  = 1'b1;
                        s_d.state = DPAB_IDLE;
                        if (s_q.cnt + 3'h1 != s_q.len || !i_wr_last) begin
                            s_d.result = DPAB_REJECTED;
                        end else if (s_q.ctrl == 8'h00) begin
                            // Stored value stays valid on a zero byte
                            s_d.result = DPAB_IGNORED;
                        end else if (!writable) begin
                            s_d.result = DPAB_REJECTED;
                        end else if (i_status[`DPAB_STAT_RUNNING]) begin
                            s_d.result = DPAB_REJECTED;
                        end else begin
                            s_d.result    = DPAB_OK;
                            s_d.ref_load  = 1'b1;
                            s_d.ref_value = {s_q.shift[23:0], i_wr_byte};
                        end
                    end
                end
            end
            DPAB_ERR: begin
                // Swallow payload of a write to an unknown number
                if (i_wr_valid && i_wr_last) begin
                    s_d.done  = 1'b1;
                    s_d.state = DPAB_IDLE;
                end
            end
            default: s_d.state = DPAB_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_q           <= '0;
            s_q.state     <= DPAB_IDLE;
            s_q.result    <= DPAB_OK;
            s_q.ref_value <= `DPAB_POS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rd_valid  = s_q.rd_valid;
    assign o_rd_byte   = s_q.rd_byte;
    assign o_rd_last   = s_q.rd_last;
    assign o_done      = s_q.done;
    assign o_result    = s_q.result;
    assign o_busy      = (s_q.state != DPAB_IDLE);
    assign o_ref_load  = s_q.ref_load;
    assign o_ref_value = s_q.ref_value;

    property p_zero_ctrl_no_load;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_WRCOL && i_wr_valid && s_q.ctrl == 8'h00 && s_q.cnt != 3'h0) |=> !o_ref_load;
    endproperty
    a_zero_ctrl_no_load: assert property (p_zero_ctrl_no_load) else $error("zero control byte applied");

    property p_load_stationary;
        @(posedge i_clock) disable iff (i_rst)
        o_ref_load |-> !$past(i_status[`DPAB_STAT_RUNNING]);
    endproperty
    a_load_stationary: assert property (p_load_stationary) else $error("re-reference while running");

    property p_load_position_only;
        @(posedge i_clock) disable iff (i_rst)
        o_ref_load |-> (s_q.param == `DPAB_PAR_POSITION && o_result == DPAB_OK && o_done);
    endproperty
    a_load_position_only: assert property (p_load_position_only) else $error("load on read-only parameter");

    property p_rd_len16;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_IDLE && i_req_valid && !i_req_write && known && !wide)
            |=> o_busy ##1 o_rd_valid ##1 (o_rd_valid && o_rd_last);
    endproperty
    a_rd_len16: assert property (p_rd_len16) else $error("16-bit read not 2 bytes");

    property p_rd_len32;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_IDLE && i_req_valid && !i_req_write && wide)
            |=> ##1 (o_rd_valid && !o_rd_last) [*3] ##1 o_rd_last;
    endproperty
    a_rd_len32: assert property (p_rd_len32) else $error("32-bit read not 4 bytes");

    property p_status_rsvd;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_IDLE && i_req_valid && !i_req_write && i_req_param == `DPAB_PAR_STATUS)
            |=> ##1 o_rd_valid ##1 (o_rd_last && o_rd_byte[3:2] == 2'b00);
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status bits set");

    property p_wr_len;
        @(posedge i_clock) disable iff (i_rst)
        (o_done && o_result == DPAB_OK && $past(s_q.state) == DPAB_WRCOL) |-> ($past(s_q.cnt) + 3'h1 == $past(s_q.len));
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write length wrong");

    property p_rd_done;
        @(posedge i_clock) disable iff (i_rst)
        o_rd_last |-> (o_done && o_rd_valid);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read end without done");

    property p_unknown_read;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_IDLE && i_req_valid && !i_req_write && !known)
            |=> (o_done && o_result == DPAB_BADPAR && !o_rd_valid);
    endproperty
    a_unknown_read: assert property (p_unknown_read) else $error("unknown number not refused");

    property p_zero_ctrl_result;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_WRCOL && i_wr_valid && i_wr_last && s_q.cnt + 3'h1 == s_q.len && s_q.ctrl == 8'h00)
            |=> (o_done && o_result == DPAB_IGNORED);
    endproperty
    a_zero_ctrl_result: assert property (p_zero_ctrl_result) else $error("zero control byte not ignored");

    property p_ro_write_rejected;
        @(posedge i_clock) disable iff (i_rst)
        (s_q.state == DPAB_WRCOL && i_wr_valid && i_wr_last && s_q.cnt + 3'h1 == s_q.len
            && s_q.ctrl != 8'h00 && !writable)
            |=> (o_done && o_result == DPAB_REJECTED && !o_ref_load);
    endproperty
    a_ro_write_rejected: assert property (p_ro_write_rejected) else $error("read-only write not refused");
endmodule

// *** tb/dpab_host.sv ***
`timescale 1ns/100ps

// Fieldbus IO controller model issuing acyclic parameter requests
module dpab_host (
    input  wire logic       i_clock,
    output logic            o_req_valid,
    output logic            o_req_write,
    output logic      [7:0] o_req_param,
    output logic            o_wr_valid,
    output logic      [7:0] o_wr_byte,
    output logic            o_wr_last,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_byte,
    input  wire logic       i_rd_last,
    input  wire logic       i_done,
    input  wire logic [1:0] i_result
);
    // Idle bus after power up
    initial begin
        o_req_valid = 1'b0;
        o_req_write = 1'b0;
        o_req_param = 8'h00;
        o_wr_valid  = 1'b0;
        o_wr_byte   = 8'h00;
        o_wr_last   = 1'b0;
    end

    // One request strobe, then the number is scrambled so a late sample shows
    task automatic start(input logic wr, input logic [7:0] p);
        @(negedge i_clock);
        o_req_valid = 1'b1;
        o_req_write = wr;
        o_req_param = p;
        @(negedge i_clock);
        o_req_valid = 1'b0;
        o_req_param = ~p;
    endtask

    // Collect answer bytes until completion, bounded so a hang cannot stall here
    task automatic finish(output logic [31:0] v, output int n, output int l, output logic [1:0] r);
        v = 32'h0000_0000;
        n = 0;
        l = 0;
        r = 2'bxx;
        for (int k = 0; k < 20; k++) begin
            if (i_rd_valid) begin
                v = {v[23:0], i_rd_byte};
                n++;
                if (i_rd_last) l = n;
            end
            if (i_done) begin
                r = i_result;
                break;
            end
            @(negedge i_clock);
        end
    endtask

    task automatic read(input logic [7:0] p, output logic [31:0] v, output int n, output int l,
                        output logic [1:0] r);
        start(1'b0, p);
        finish(v, n, l, r);
    endtask

    // Control byte leads, value follows MSB first; last_at may end the frame early
    task automatic write(input logic [7:0] p, input logic [7:0] c, input logic [31:0] v,
                         input int nb, input int last_at, output logic [1:0] r);
        logic [31:0] d;
        int          n;
        int          l;
        start(1'b1, p);
        for (int i = 0; i <= nb; i++) begin
            o_wr_valid = 1'b1;
            o_wr_byte  = (i == 0) ? c : v[8*(nb-i)+:8];
            o_wr_last  = (i == last_at);
            @(negedge i_clock);
            if (i == last_at) break;
        end
        o_wr_valid = 1'b0;
        o_wr_last  = 1'b0;
        o_wr_byte  = ~o_wr_byte;
        finish(d, n, l, r);
    endtask
endmodule

// *** tb/drive_parameter_access_bank_tb.sv ***
`timescale 1ns/100ps

module drive_parameter_access_bank_tb;
    import dpab_pkg::*;

    logic         clock, rst, req_valid, req_write, wr_valid, wr_last;
    logic         rd_valid, rd_last, done, busy, run_start, run_steady, ref_load;
    logic [7:0]   req_param, wr_byte, rd_byte;
    dpab_result_t result;
    logic [15:0]  status, speed, torque, u_logic, u_motor, temperature, switch_pins, year_week, serial;
    logic [31:0]  position, ref_value;
    int           errors, checked, loads;

    dpab_bank dpab_bank_inst (.i_clock(clock), .i_rst(rst), .i_req_valid(req_valid), .i_req_write(req_write),
        .i_req_param(req_param), .i_wr_valid(wr_valid), .i_wr_byte(wr_byte), .i_wr_last(wr_last),
        .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_rd_last(rd_last), .o_done(done), .o_result(result),
        .o_busy(busy), .i_status(status), .i_speed(speed), .i_position(position), .i_torque(torque),
        .i_run_start(run_start), .i_run_steady(run_steady), .i_u_logic(u_logic), .i_u_motor(u_motor),
        .i_temperature(temperature), .i_switch_pins(switch_pins), .i_year_week(year_week),
        .i_serial(serial), .o_ref_load(ref_load), .o_ref_value(ref_value));

    dpab_host dpab_host_inst (.i_clock(clock), .o_req_valid(req_valid), .o_req_write(req_write),
        .o_req_param(req_param), .o_wr_valid(wr_valid), .o_wr_byte(wr_byte), .o_wr_last(wr_last),
        .i_rd_valid(rd_valid), .i_rd_byte(rd_byte), .i_rd_last(rd_last), .i_done(done),
        .i_result(result));

    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Count re-reference pulses mid-cycle, where the registered pulse has settled
    always @(negedge clock) begin
        if (ref_load === 1'b1) loads++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Read one parameter and judge value, byte count, last marker and result
    task automatic rd(input logic [7:0] p, input int nb, input logic [31:0] exp, input string name);
        logic [31:0] v;
        int          n;
        int          l;
        logic [1:0]  r;
        dpab_host_inst.read(p, v, n, l, r);
        check(name, v, exp);
        check(name, n, nb);
        check(name, l, nb);
        check(name, r, DPAB_OK);
        @(negedge clock);
        check("busy", busy, 1'b0);
    endtask

    // Write one parameter and judge result and whether a re-reference fired
    task automatic wr(input logic [7:0] p, input logic [7:0] c, input logic [31:0] v, input int nb,
                      input int last_at, input logic [1:0] exp_r, input int exp_load);
        int         l0;
        logic [1:0] r;
        l0 = loads;
        dpab_host_inst.write(p, c, v, nb, last_at, r);
        @(negedge clock);
        check("write result", r, exp_r);
        check("load count", loads - l0, exp_load);
        if (exp_load > 0) check("ref value", ref_value, v);
    endtask

    task automatic t_reads();
        logic [31:0] v;
        int          n;
        int          l;
        logic [1:0]  r;
        rd(8'h01, 2, 32'h0000_fff3, "status");
        status = 16'h000c;
        rd(8'h01, 2, 32'h0000_0000, "status rsvd");
        rd(8'h02, 2, {16'h0, speed}, "speed");
        rd(8'h03, 4, position, "position");
        rd(8'h04, 2, {16'h0, torque}, "torque");
        rd(8'h06, 2, {16'h0, u_logic}, "ulogic");
        rd(8'h07, 2, {16'h0, u_motor}, "umotor");
        rd(8'h08, 2, {16'h0, temperature}, "temp");
        rd(8'h09, 2, {16'h0, switch_pins}, "switch");
        rd(8'h0a, 2, {16'h0, year_week}, "date");
        rd(8'h0b, 2, {16'h0, serial}, "serial");
        dpab_host_inst.read(8'h0c, v, n, l, r);
        check("unknown result", r, DPAB_BADPAR);
        check("unknown bytes", n, 0);
    endtask

    task automatic t_writes();
        status = 16'h0000;
        wr(8'h03, 8'h01, 32'h8000_1234, 4, 4, DPAB_OK, 1);
        wr(8'h03, 8'h80, 32'h7fff_fffe, 4, 4, DPAB_OK, 1);
        wr(8'h03, 8'h00, 32'h0bad_0bad, 4, 4, DPAB_IGNORED, 0);
        check("ref hold", ref_value, 32'h7fff_fffe);
        wr(8'h03, 8'h01, 32'h0000_1111, 4, 2, DPAB_REJECTED, 0);
        status = 16'h0040;
        wr(8'h03, 8'h01, 32'h0000_2222, 4, 4, DPAB_REJECTED, 0);
        status = 16'h0000;
        wr(8'h08, 8'h01, 32'h0000_1234, 2, 2, DPAB_REJECTED, 0);
        wr(8'h0c, 8'h01, 32'h0000_1234, 2, 2, DPAB_BADPAR, 0);
        rd(8'h08, 2, {16'h0, temperature}, "temp after write");
    endtask

    // Torque outside the steady phase must never reach the peak
    task automatic t_peak();
        @(negedge clock);
        run_start = 1'b1;
        @(negedge clock);
        run_start = 1'b0;
        torque    = 16'h0900;
        repeat (3) @(negedge clock);
        run_steady = 1'b1;
        torque     = 16'h0100;
        repeat (2) @(negedge clock);
        torque = 16'h0300;
        repeat (2) @(negedge clock);
        torque = 16'h0200;
        repeat (2) @(negedge clock);
        run_steady = 1'b0;
        torque     = 16'h0a00;
        repeat (3) @(negedge clock);
        rd(8'h05, 2, 32'h0000_0300, "peak");
        run_start = 1'b1;
        @(negedge clock);
        run_start = 1'b0;
        repeat (2) @(negedge clock);
        rd(8'h05, 2, 32'h0000_0000, "peak cleared");
    endtask

    // A mid-run reset must clear the peak and the re-reference value
    task automatic t_reset();
        run_steady = 1'b1;
        torque     = 16'h0400;
        repeat (2) @(negedge clock);
        run_steady = 1'b0;
        rst        = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        check("ref after reset", ref_value, 32'h0000_0000);
        check("busy after reset", busy, 1'b0);
        rd(8'h05, 2, 32'h0000_0000, "peak after reset");
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        #160000;
        errors++;
        complete_run();
    end

    // Main sequence
    initial begin
        errors = 0;
        checked = 0;
        loads = 0;
        rst = 1'b1;
        status = 16'hffff;
        speed = 16'h8123;
        position = 32'hfedc_ba98;
        torque = 16'h0042;
        run_start = 1'b0;
        run_steady = 1'b0;
        u_logic = 16'h00f0;
        u_motor = 16'h00f1;
        temperature = 16'h0029;
        switch_pins = 16'h005a;
        year_week = 16'h0937;
        serial = 16'hc3a5;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        check("ref reset", ref_value, 32'h0000_0000);
        t_reads();
        t_writes();
        t_peak();
        t_reset();
        complete_run();
    end
endmodule
